/* core/dbd_regs.vh */
// Constants for the debug breakpoint detection logic: field positions, encodings and reset values.
// Assumes inclusion by bare name from the design files of this block.
`ifndef DBD_REGS_VH
`define DBD_REGS_VH
`define DBD_NUM_BP          4
`define DBD_VECTOR          8'h01
`define DBD_RW_EXEC         2'h0
`define DBD_RW_WRITE        2'h1
`define DBD_RW_IO           2'h2
`define DBD_RW_RDWR         2'h3
`define DBD_LEN_1           2'h0
`define DBD_LEN_2           2'h1
`define DBD_LEN_8           2'h2
`define DBD_LEN_4           2'h3
`define DBD_CTL_GD_BIT      13
`define DBD_ST_BD_BIT       13
`define DBD_ST_BS_BIT       14
`define DBD_ST_BT_BIT       15
`define DBD_CTL_RESET       32'h00000400
`define DBD_STATUS_RESET    16'h0000
`endif

/* core/dbd_match.v */
// Address comparator for one breakpoint address register against one access.
// Assumes access size is one to eight bytes, given as a byte count minus one.
module dbd_match #(
  parameter AW = 64
) (
  input  wire [AW-1:0] bp_addr,   // Breakpoint address register value.
  input  wire [1:0]    len,       // Match length field.
  input  wire [AW-1:0] acc_addr,  // First byte of the access.
  input  wire [2:0]    acc_size_m1, // Access size in bytes minus one.
  output wire          hit        // Some accessed byte lies inside the range.
);
`include "dbd_regs.vh"

  // Mask of low address bits ignored for a given length encoding.
  function [AW-1:0] low_mask;
    input [1:0] l;
    begin
      case (l)
        `DBD_LEN_2: low_mask = {{(AW-1){1'b0}}, 1'b1};
        `DBD_LEN_4: low_mask = {{(AW-2){1'b0}}, 2'h3};
        `DBD_LEN_8: low_mask = {{(AW-3){1'b0}}, 3'h7};
        default:    low_mask = {AW{1'b0}};
      endcase
    end
  endfunction

  wire [AW-1:0] mask     = low_mask(len);
  wire [AW-1:0] rng_lo   = bp_addr & ~mask;
  wire [AW-1:0] rng_hi   = rng_lo | mask;
  wire [AW-1:0] acc_last = acc_addr + {{(AW-3){1'b0}}, acc_size_m1};

  // Ranges overlap when neither lies wholly beyond the other.
  assign hit = (acc_addr <= rng_hi) && (acc_last >= rng_lo);
endmodule // dbd_match

/* core/dbd_step.v */
// Single-step tracker: follows the trap flag and decides when a step trap is due.
// Assumes one retire pulse per completed instruction from the pipeline.
module dbd_step (
  input  wire clk,         // Core clock.
  input  wire reset,       // Synchronous reset, active high.
  input  wire retire,      // One instruction completed this cycle.
  input  wire trap_flag,   // Trap flag value after the retiring instruction.
  output reg  step_due     // A step trap is due for this retiring instruction.
);
  reg armed_cnt_done;      // Trap flag has been seen set across one retirement.
  reg seen_set;            // Trap flag was set after the previous retirement.

  // Skip the setting instruction and the next one before stepping begins.
  always @* begin
    step_due = retire & trap_flag & seen_set & armed_cnt_done;
  end

  // Track how many retirements have passed with the trap flag set.
  always @(posedge clk) begin
    if (reset) begin
      seen_set       <= 1'b0;
      armed_cnt_done <= 1'b0;
    end else if (retire) begin
      armed_cnt_done <= trap_flag & seen_set;
      seen_set       <= trap_flag;
    end
  end
endmodule // dbd_step

/* core/dbd_detect.v */
// Debug condition detection: breakpoints, task-switch, guarded access and single step.
// Assumes the pipeline presents one instruction at a time and acknowledges each request with taken.
`include "dbd_regs.vh"
// Summary of operation
// - Instruction and guard hits fault before execution; others trap after.
// - Debug exception uses interrupt vector one.
// - Pending data traps precede next instruction match; same instruction: fault first.
// - Breakpoint armed only when its local or global enable is set.
// - Execute type with one-byte length matches next instruction address.
// - Instruction match sets hit flag, returns to matched instruction.
// - Resume flag suppresses instruction matches for one instruction, then clears.
// - Type 01 matches writes, type 11 reads and writes.
// - Length codes one, two, four, eight bytes; eight only in long mode.
// - Data match traps after instruction, sets hit, returns to next instruction.
// - Repeated string data match may return to the string instruction.
// - Type 10 is an I/O match only with the I/O extension bit set.
// - I/O lengths are byte, word and doubleword operations.
// - I/O port address is zero-extended to 64 bits before compare.
// - Repeated string port I/O traps after each iteration while matching.
// - Task-breakpoint switch traps before first instruction, sets task hit.
// - Guarded register access faults, clears guard, sets access hit.
// - Trap flag steps every instruction except the setter and its follower.
// - Step trap clears trap flag, sets step hit, pushed flags keep it.
// - Step trap wins over external interrupt, taken in handler entry.
// - Software interrupt, one-byte breakpoint, overflow trap clear trap flag.
// - Task switch clears local enables, never global ones.
// - Match when any accessed byte lies in the masked range.
module dbd_detect #(
  parameter AW = 64,
  parameter NB = `DBD_NUM_BP
) (
  input  wire            clk,            // Core clock.
  input  wire            reset,          // Synchronous reset, active high.
  input  wire [AW*NB-1:0] bp_addr,       // Breakpoint address registers, packed.
  input  wire            ctl_wr,         // Write to the debug control register.
  input  wire [31:0]     ctl_wdata,      // Write data for the control register.
  input  wire            status_clr,     // Software clears the status flags.
  input  wire            io_trap_extension_on, // I/O breakpoint extension enable.
  input  wire            long_mode,      // Long mode active.
  input  wire            fetch_valid,    // Next instruction about to execute.
  input  wire [AW-1:0]   fetch_addr,     // Virtual address of next instruction.
  input  wire            fetch_dr_access,// Next instruction accesses a breakpoint register.
  input  wire            retire,         // Instruction completed this cycle.
  input  wire [AW-1:0]   retire_addr,    // Address of completed instruction.
  input  wire [AW-1:0]   next_addr,      // Address of following instruction.
  input  wire            mem_rd,         // Completed instruction read memory.
  input  wire            mem_wr,         // Completed instruction wrote memory.
  input  wire [AW-1:0]   mem_addr,       // Data virtual address.
  input  wire [2:0]      mem_size_m1,    // Data size minus one.
  input  wire            io_acc,         // Completed instruction did port I/O.
  input  wire [15:0]     io_port,        // Port address.
  input  wire [2:0]      io_size_m1,     // Port size minus one.
  input  wire            rep_incomplete, // Repeated string loop not yet finished.
  input  wire            trap_flag,      // Trap flag after the completed instruction.
  input  wire            resume_flag,    // Resume flag.
  input  wire            clr_tf_instr,   // Completed instruction is a software interrupt kind.
  input  wire            task_switch,    // Task switch finished loading state.
  input  wire            task_bp_bit,    // New task has its breakpoint bit set.
  input  wire            ext_irq,        // External interrupt pending.
  input  wire            taken,          // Sequencer accepted the request.
  output reg             fault_req,      // Fault request before execution.
  output reg             trap_req,       // Trap request after execution.
  output wire [7:0]      vector,         // Exception vector number.
  output reg  [AW-1:0]   ret_addr,       // Return address to push.
  output reg             push_tf,        // Trap flag value for pushed flags image.
  output reg             clear_tf,       // Clear trap flag on entry.
  output reg             clear_rf,       // Clear resume flag.
  output reg             irq_after,      // Take pending interrupt before handler runs.
  output reg  [31:0]     debug_control_reg, // Debug control register.
  output reg  [15:0]     debug_status_reg   // Debug status register.
);

  // Exception vector is constant.
  assign vector = `DBD_VECTOR;

  wire [NB-1:0] i_hit;
  wire [NB-1:0] d_hit;
  wire [NB-1:0] p_hit;
  wire          step_due;
  wire [AW-1:0] io_addr = {{(AW-16){1'b0}}, io_port};

  // Field helpers for the control register.
  function armed;
    input [31:0] c;
    input integer n;
    begin
      armed = c[2*n] | c[2*n+1];
    end
  endfunction

  function [1:0] rw_of;
    input [31:0] c;
    input integer n;
    begin
      rw_of = c[16+4*n +: 2];
    end
  endfunction

  function [1:0] len_of;
    input [31:0] c;
    input integer n;
    begin
      len_of = c[18+4*n +: 2];
    end
  endfunction

  // Per-register comparators for fetch, data and port accesses.
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_bp
      wire [1:0] rw  = rw_of(debug_control_reg, g);
      wire [1:0] len = len_of(debug_control_reg, g);
      wire       en  = armed(debug_control_reg, g);
      wire       len_ok = (len != `DBD_LEN_8) | long_mode;
      wire       fm, dm, pm;
      dbd_match #(.AW(AW)) u_f (
        .bp_addr     (bp_addr[g*AW +: AW]),
        .len         (`DBD_LEN_1),
        .acc_addr    (fetch_addr),
        .acc_size_m1 (3'h0),
        .hit         (fm)
      );
      dbd_match #(.AW(AW)) u_d (
        .bp_addr     (bp_addr[g*AW +: AW]),
        .len         (len),
        .acc_addr    (mem_addr),
        .acc_size_m1 (mem_size_m1),
        .hit         (dm)
      );
      dbd_match #(.AW(AW)) u_p (
        .bp_addr     (bp_addr[g*AW +: AW]),
        .len         (len),
        .acc_addr    (io_addr),
        .acc_size_m1 (io_size_m1),
        .hit         (pm)
      );
      // Execute match needs the one-byte length.
      assign i_hit[g] = en & fetch_valid & (rw == `DBD_RW_EXEC) & (len == `DBD_LEN_1) & fm;
      // Data match by access type.
      assign d_hit[g] = en & len_ok & dm &
                        (((rw == `DBD_RW_WRITE) & mem_wr) |
                         ((rw == `DBD_RW_RDWR) & (mem_rd | mem_wr)));
      // Port match only under the extension bit; length selects byte, word, doubleword.
      assign p_hit[g] = en & io_trap_extension_on & io_acc & (rw == `DBD_RW_IO) &
                        (len != `DBD_LEN_8) & pm;
    end
  endgenerate

  dbd_step u_step (
    .clk       (clk),
    .reset     (reset),
    .retire    (retire),
    .trap_flag (trap_flag),
    .step_due  (step_due)
  );

  // Pending trap state captured at retirement or task switch, held until taken.
  reg          pend;
  reg [NB-1:0] pend_bits;
  reg          pend_bt;
  reg          pend_bs;
  reg [AW-1:0] pend_ret;
  reg          pend_irq;

  wire         any_trap  = (|d_hit) | (|p_hit) | step_due;
  wire         guard_hit = fetch_valid & fetch_dr_access & debug_control_reg[`DBD_CTL_GD_BIT];
  wire         inst_hit  = (|i_hit) & ~resume_flag;
  wire         tsk_hit   = task_switch & task_bp_bit;

  // Request outputs: pending trap has priority over a fetch fault.
  always @* begin
    trap_req  = pend;
    fault_req = ~pend & (inst_hit | guard_hit);
    push_tf   = 1'b0;
    // Software interrupt, one-byte breakpoint and overflow trap drop the trap flag as they complete.
    clear_tf  = retire & clr_tf_instr;
    irq_after = 1'b0;
    ret_addr  = fetch_addr;
    if (pend) begin
      ret_addr  = pend_ret;
      push_tf   = pend_bs;
      clear_tf  = clear_tf | pend_bs;
      irq_after = pend_irq & pend_bs;
    end
  end

  // Resume flag cleared after the next instruction completes.
  always @* begin
    clear_rf = retire & resume_flag;
  end

  // Capture after-execution conditions; new events win over the take.
  always @(posedge clk) begin
    if (reset) begin
      pend      <= 1'b0;
      pend_bits <= {NB{1'b0}};
      pend_bt   <= 1'b0;
      pend_bs   <= 1'b0;
      pend_ret  <= {AW{1'b0}};
      pend_irq  <= 1'b0;
    end else if (retire & any_trap & ~clr_tf_instr) begin
      pend      <= 1'b1;
      pend_bits <= d_hit | p_hit;
      pend_bt   <= 1'b0;
      pend_bs   <= step_due;
      pend_irq  <= ext_irq;
      // Unfinished repeated string loop returns to itself.
      pend_ret  <= rep_incomplete ? retire_addr : next_addr;
    end else if (retire & ((|d_hit) | (|p_hit))) begin
      pend      <= 1'b1;
      pend_bits <= d_hit | p_hit;
      pend_bt   <= 1'b0;
      pend_bs   <= 1'b0;
      pend_irq  <= 1'b0;
      pend_ret  <= rep_incomplete ? retire_addr : next_addr;
    end else if (tsk_hit) begin
      pend      <= 1'b1;
      pend_bits <= {NB{1'b0}};
      pend_bt   <= 1'b1;
      pend_bs   <= 1'b0;
      pend_irq  <= 1'b0;
      pend_ret  <= fetch_addr;
    end else if (taken & pend) begin
      pend      <= 1'b0;
    end
  end

  // Next control value: a software write first, then the hardware clears on top of it.
  // Layering the clears keeps a task switch or guard fault from being lost beside a write.
  reg [31:0] next_ctl;
  integer    k;
  always @* begin
    next_ctl = debug_control_reg;
    if (ctl_wr) begin
      next_ctl = ctl_wdata;
    end
    // A task switch drops every local enable and leaves the global ones alone.
    if (task_switch) begin
      for (k = 0; k < NB; k = k + 1) begin
        next_ctl[2*k] = 1'b0;
      end
    end
    // A taken guard fault clears the guard so the handler may reach the registers.
    if (taken & ~pend & guard_hit) begin
      next_ctl[`DBD_CTL_GD_BIT] = 1'b0;
    end
  end

  // Control register state.
  always @(posedge clk) begin
    if (reset) begin
      debug_control_reg <= `DBD_CTL_RESET;
    end else begin
      debug_control_reg <= next_ctl;
    end
  end

  // Status flags updated when a request is taken; the set wins over a clear.
  always @(posedge clk) begin
    if (reset) begin
      debug_status_reg <= `DBD_STATUS_RESET;
    end else if (taken & pend) begin
      debug_status_reg[NB-1:0]          <= (status_clr ? {NB{1'b0}} : debug_status_reg[NB-1:0]) | pend_bits;
      debug_status_reg[`DBD_ST_BT_BIT]  <= (debug_status_reg[`DBD_ST_BT_BIT] & ~status_clr) | pend_bt;
      debug_status_reg[`DBD_ST_BS_BIT]  <= (debug_status_reg[`DBD_ST_BS_BIT] & ~status_clr) | pend_bs;
      debug_status_reg[`DBD_ST_BD_BIT]  <= debug_status_reg[`DBD_ST_BD_BIT] & ~status_clr;
    end else if (taken & fault_req) begin
      debug_status_reg[NB-1:0] <= (status_clr ? {NB{1'b0}} : debug_status_reg[NB-1:0]) |
                                  (inst_hit ? i_hit : {NB{1'b0}});
      debug_status_reg[`DBD_ST_BD_BIT] <= (debug_status_reg[`DBD_ST_BD_BIT] & ~status_clr) | guard_hit;
      debug_status_reg[`DBD_ST_BT_BIT] <= debug_status_reg[`DBD_ST_BT_BIT] & ~status_clr;
      debug_status_reg[`DBD_ST_BS_BIT] <= debug_status_reg[`DBD_ST_BS_BIT] & ~status_clr;
    end else if (status_clr) begin
      debug_status_reg <= `DBD_STATUS_RESET;
    end
  end
endmodule // dbd_detect

/* verif/dbd_detect_assertions.sv */
// Checker for the debug condition detector, watching its top-level ports only.
// Assumes one core clock and a synchronous active-high reset.
module dbd_detect_assertions #(
  parameter AW = 64
) (
  input wire logic          clk,               // Core clock.
  input wire logic          reset,             // Synchronous reset.
  input wire logic          retire,            // Instruction completed.
  input wire logic          task_switch,       // Task switch done.
  input wire logic          taken,             // Request accepted.
  input wire logic          fetch_valid,       // Next instruction shown.
  input wire logic [AW-1:0] fetch_addr,        // Next instruction address.
  input wire logic          fetch_dr_access,   // Breakpoint register access.
  input wire logic          resume_flag,       // Resume flag.
  input wire logic          ctl_wr,            // Control write.
  input wire logic          fault_req,         // Before-execution request.
  input wire logic          trap_req,          // After-execution request.
  input wire logic [7:0]    vector,            // Vector number.
  input wire logic [AW-1:0] ret_addr,          // Return address.
  input wire logic          clear_rf,          // Resume flag clear.
  input wire logic [31:0]   debug_control_reg, // Control register.
  input wire logic [15:0]   debug_status_reg   // Status register.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Vector, request timing and ordering, return address, resume clear, guard and enable updates.
  vector_one_a: assert property (vector == 8'h01) else $error("vector is not one");
  trap_cause_a: assert property ($rose(trap_req) |-> $past(retire || task_switch))
    else $error("trap request without a cause");
  trap_hold_a: assert property (trap_req && !taken |=> trap_req) else $error("trap dropped early");
  trap_drop_a: assert property (trap_req && taken && !retire && !task_switch |=> !trap_req)
    else $error("trap stands after acceptance");
  fault_masked_a: assert property (trap_req |-> !fault_req) else $error("fault beside pending trap");
  fault_addr_a: assert property (fault_req |-> fetch_valid && ret_addr == fetch_addr)
    else $error("fault return address wrong");
  resume_mask_a: assert property (fault_req && resume_flag |-> fetch_dr_access)
    else $error("instruction match under resume flag");
  clear_rf_a: assert property (clear_rf == (retire && resume_flag)) else $error("resume clear wrong");
  guard_clear_a: assert property (fault_req && taken && fetch_dr_access && debug_control_reg[13] && !ctl_wr
    |=> !debug_control_reg[13] && debug_status_reg[13]) else $error("guard fault not recorded");
  global_keep_a: assert property (task_switch && !ctl_wr |=>
    debug_control_reg[7:0] == ($past(debug_control_reg[7:0]) & 8'haa)) else $error("enables wrong");
  // Main scenarios reached.
  trap_taken_c: cover property (trap_req && taken);
  fault_taken_c: cover property (fault_req && taken);
  task_trap_c: cover property (task_switch ##1 trap_req);
endmodule // dbd_detect_assertions

/* verif/dbd_seq_model.sv */
// Exception sequencer model: acknowledges fault and trap requests of the detector.
// Assumes one core clock; the bench stalls it to keep a request pending.
module dbd_seq_model (
  input  wire logic clk,       // Core clock.
  input  wire logic reset,     // Synchronous reset.
  input  wire logic fault_req, // Before-execution request.
  input  wire logic trap_req,  // After-execution request.
  input  wire logic stall,     // Holds off acceptance.
  output logic      taken      // One-cycle acceptance pulse.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Accept a standing request a cycle later, never on two edges in a row.
  always_ff @(posedge clk) begin
    if (reset) taken <= 1'h0;
    else taken <= (fault_req | trap_req) & ~stall & ~taken;
  end
endmodule // dbd_seq_model

/* verif/testbench.sv */
// Self-checking bench for the debug condition detector with a sequencer model.
// Assumes the design under core and the model and checker under verif.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [63:0] RA = 64'h1000, NA = 64'h1004;
  logic clk = 1'h0, reset = 1'h1, ctl_wr = 1'h0, status_clr = 1'h0, io_trap_extension_on = 1'h0;
  logic long_mode = 1'h0, fetch_valid = 1'h0, fetch_dr_access = 1'h0, retire = 1'h0, mem_rd = 1'h0;
  logic mem_wr = 1'h0, io_acc = 1'h0, rep_incomplete = 1'h0, trap_flag = 1'h0, resume_flag = 1'h0;
  logic clr_tf_instr = 1'h0, task_switch = 1'h0, task_bp_bit = 1'h0, ext_irq = 1'h0, stall = 1'h0;
  logic [255:0] bp_addr = 256'h0;
  logic [31:0] ctl_wdata = 32'h0, debug_control_reg;
  logic [63:0] fetch_addr = 64'h0, retire_addr = RA, next_addr = NA, mem_addr = 64'h0, ret_addr;
  logic [15:0] io_port = 16'h0, debug_status_reg;
  logic [2:0] mem_size_m1 = 3'h0, io_size_m1 = 3'h0, seen;
  logic [7:0] vector;
  logic taken, fault_req, trap_req, push_tf, clear_tf, clear_rf, irq_after;
  int n_fail = 0, n_tests = 0;
  // Core clock at 200 MHz.
  initial forever #2.5 clk = ~clk;
  dbd_detect dut_u (.clk, .reset, .bp_addr, .ctl_wr, .ctl_wdata, .status_clr, .io_trap_extension_on,
    .long_mode, .fetch_valid, .fetch_addr, .fetch_dr_access, .retire, .retire_addr, .next_addr, .mem_rd,
    .mem_wr, .mem_addr, .mem_size_m1, .io_acc, .io_port, .io_size_m1, .rep_incomplete, .trap_flag,
    .resume_flag, .clr_tf_instr, .task_switch, .task_bp_bit, .ext_irq, .taken, .fault_req, .trap_req,
    .vector, .ret_addr, .push_tf, .clear_tf, .clear_rf, .irq_after, .debug_control_reg, .debug_status_reg);
  dbd_seq_model seq_u (.clk, .reset, .fault_req, .trap_req, .stall, .taken);
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input [63:0] got, input [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Writes the control register and clears the status flags in the same cycle.
  task automatic wctl(input [31:0] v);
    @(negedge clk);
    ctl_wr = 1'h1;
    status_clr = 1'h1;
    ctl_wdata = v;
    @(negedge clk);
    ctl_wr = 1'h0;
    status_clr = 1'h0;
  endtask
  // Pulses a retirement or task switch, then checks the trap and the flags left behind.
  task automatic event_chk(input ts, input exp, input [63:0] eret, input [15:0] ebits);
    int i;
    @(negedge clk);
    if (ts) task_switch = 1'h1;
    else retire = 1'h1;
    #1 chk(clear_rf, !ts && resume_flag);
    chk(clear_tf, !ts && clr_tf_instr);
    @(negedge clk);
    task_switch = 1'h0;
    retire = 1'h0;
    chk(trap_req, exp);
    if (exp && !ts) chk(ret_addr, eret);
    seen = {push_tf, clear_tf, irq_after};
    for (i = 0; i < 8 && trap_req !== 1'h0; i++) @(negedge clk);
    chk(trap_req, 1'h0);
    chk(debug_status_reg, ebits);
  endtask
  // Presents the next instruction and checks the fault and its acceptance.
  task automatic fault_chk(input exp, input [15:0] ebits);
    int i;
    @(negedge clk);
    fetch_valid = 1'h1;
    #1 chk(fault_req, exp);
    if (exp) chk(ret_addr, fetch_addr);
    for (i = 0; i < 8 && exp && taken !== 1'h1; i++) @(negedge clk);
    @(negedge clk);
    fetch_valid = 1'h0;
    chk(debug_status_reg, ebits);
  endtask
  // One access of kind k (read, write, port, none) against all four address registers set to b.
  task automatic acc(input [31:0] c, input [63:0] b, input lm, input [1:0] k, input [63:0] a,
                     input [2:0] m1, input rep, input exp, input [15:0] eb);
    wctl(c);
    bp_addr = {4{b}};
    long_mode = lm;
    mem_rd = (k == 2'h0);
    mem_wr = (k == 2'h1);
    io_acc = (k == 2'h2);
    mem_addr = a;
    io_port = a[15:0];
    mem_size_m1 = m1;
    io_size_m1 = m1;
    rep_incomplete = rep;
    event_chk(1'h0, exp, rep ? RA : NA, exp ? eb : 16'h0);
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'h0;
    chk(debug_control_reg, 32'h400);
    chk(debug_status_reg, 16'h0);
    chk(vector, 8'h01);
    acc(32'h00030401, 64'hf000, 0, 0, 64'heffb, 7, 0, 1, 16'h1);
    acc(32'h00030401, 64'hf000, 0, 0, 64'heffe, 1, 0, 0, 16'h1);
    acc(32'h00030401, 64'hf000, 0, 1, 64'heffe, 3, 0, 1, 16'h1);
    acc(32'h00030401, 64'hf000, 0, 0, 64'hf001, 1, 0, 0, 16'h1);
    acc(32'h000f0401, 64'hf004, 0, 0, 64'hf005, 3, 0, 1, 16'h1);
    acc(32'h000f0401, 64'hf004, 0, 0, 64'heffe, 3, 0, 0, 16'h1);
    acc(32'h000b0401, 64'hf005, 1, 0, 64'hf000, 0, 0, 1, 16'h1);
    acc(32'h000b0401, 64'hf005, 1, 0, 64'heffe, 1, 0, 0, 16'h1);
    acc(32'h000b0401, 64'hf005, 0, 0, 64'hf000, 0, 0, 0, 16'h1);
    acc(32'h00010401, 64'hf000, 0, 0, 64'hf000, 0, 0, 0, 16'h1);
    acc(32'h00010401, 64'hf000, 0, 1, 64'hf000, 0, 1, 1, 16'h1);
    acc(32'h00010400, 64'hf000, 0, 1, 64'hf000, 0, 0, 0, 16'h1);
    acc(32'h10000480, 64'hf000, 0, 1, 64'hf000, 0, 0, 1, 16'h8);
    io_trap_extension_on = 1'h1;
    acc(32'h00200404, 64'h3f8, 0, 2, 64'h3f8, 0, 0, 1, 16'h2);
    acc(32'h00600404, 64'h3f8, 0, 2, 64'h3f9, 0, 1, 1, 16'h2);
    acc(32'h00e00404, 64'h3f8, 0, 2, 64'h3fb, 0, 0, 1, 16'h2);
    acc(32'h00200404, 64'h1000003f8, 0, 2, 64'h3f8, 0, 0, 0, 16'h2);
    io_trap_extension_on = 1'h0;
    acc(32'h00200404, 64'h3f8, 0, 2, 64'h3f8, 0, 0, 0, 16'h2);
    acc(32'h00000400, 64'h0, 0, 3, 64'h0, 0, 0, 0, 16'h0);
    wctl(32'h00000420);
    bp_addr = {4{64'h2000}};
    fetch_addr = 64'h2000;
    fault_chk(1'h1, 16'h4);
    resume_flag = 1'h1;
    fault_chk(1'h0, 16'h4);
    event_chk(1'h0, 1'h0, NA, 16'h4);
    resume_flag = 1'h0;
    // A data trap pending from one instruction holds off the fetch match of the next.
    wctl(32'h00010421);
    bp_addr = {64'h0, 64'h2000, 64'h0, 64'hf000};
    mem_wr = 1'h1;
    mem_addr = 64'hf000;
    stall = 1'h1;
    @(negedge clk);
    retire = 1'h1;
    @(negedge clk);
    retire = 1'h0;
    fetch_valid = 1'h1;
    #1 chk(fault_req, 1'h0);
    stall = 1'h0;
    repeat (3) @(negedge clk);
    #1 chk(fault_req, 1'h1);
    chk(debug_status_reg, 16'h1);
    @(negedge clk);
    fetch_valid = 1'h0;
    mem_wr = 1'h0;
    chk(debug_status_reg, 16'h5);
    wctl(32'h00002400);
    fetch_dr_access = 1'h1;
    fault_chk(1'h1, 16'h2000);
    chk(debug_control_reg[13], 1'h0);
    fetch_dr_access = 1'h0;
    wctl(32'h000004ff);
    task_bp_bit = 1'h1;
    event_chk(1'h1, 1'h1, NA, 16'h8000);
    chk(debug_control_reg[7:0], 8'haa);
    task_bp_bit = 1'h0;
    event_chk(1'h1, 1'h0, NA, 16'h8000);
    wctl(32'h00000400);
    trap_flag = 1'h1;
    event_chk(1'h0, 1'h0, NA, 16'h0);
    event_chk(1'h0, 1'h0, NA, 16'h0);
    ext_irq = 1'h1;
    event_chk(1'h0, 1'h1, NA, 16'h4000);
    chk(seen, 3'h7);
    ext_irq = 1'h0;
    clr_tf_instr = 1'h1;
    event_chk(1'h0, 1'h0, NA, 16'h4000);
    give_verdict;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule // testbench
bind dbd_detect dbd_detect_assertions #(.AW(AW)) chk_u (.clk, .reset, .retire, .task_switch, .taken,
  .fetch_valid, .fetch_addr, .fetch_dr_access, .resume_flag, .ctl_wr, .fault_req, .trap_req, .vector,
  .ret_addr, .clear_rf, .debug_control_reg, .debug_status_reg);
